// [verilog/spc_pkg.sv]
// Package with register offsets, field positions and reset values.
// What this block does
// - With the port-1 frame-error access select set, control bit 7 reads and writes as a sticky frame error flag cleared only by software.
// - The two mode bits choose synchronous 8-bit, asynchronous 10-bit or asynchronous 11-bit frames, and modes 1 and 3 divide the timer overflow by 16.
// - The port-1 multiprocessor enable has no effect in mode 0.
// - In mode 1 a set multiprocessor enable accepts a frame only with stop bit 1 and a matching address, otherwise every frame is accepted.
// - In modes 2 and 3 a set multiprocessor enable accepts a frame only with ninth bit 1 and a matching address, otherwise every frame is accepted.
// - Receive enable at 0 blocks reception and at 1 allows it in modes 1 to 3.
// - In mode 0 a synchronous reception starts only while receive enable is 1 and the receive done flag is 0.
// - In modes 2 and 3 the ninth transmit bit control is sent as the ninth data bit and it is ignored in modes 0 and 1.
// - The ninth receive bit captures the ninth bit in modes 2 and 3, the stop bit in mode 1, and is untouched in mode 0.
// - The transmit done flag is set when a frame has been sent.
// - The receive done flag is set at the end of a frame, and with multiprocessor enable set only for an accepted frame.
// - The done flags raise the serial interrupt while it is enabled and only software clears them.
// - The port-0 baud doubling bit doubles the rate in mode 2, and in modes 1 and 3 when timer 1 is the source.
// - The port-0 access select routes control bit 7 to the mode bit at 0 and to the frame error flag at 1.
// - The port-1 access select is bit 6 of the timer 3 control register and steers port-1 control bit 7.
package spc_pkg;
	localparam logic [7:0] ADDR_PWR = 8'h87;
	localparam logic [7:0] ADDR_P0CTL = 8'h98;
	localparam logic [7:0] ADDR_P1CTL = 8'hF8;
	localparam logic [7:0] ADDR_T3CTL = 8'hC4;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'hE0;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'hE1;
	localparam logic [7:0] ADDR_P1ADDR = 8'hE2;
	localparam logic [7:0] ADDR_P1BCAST = 8'hE3;
	localparam int BIT_MODE_HI = 7;
	localparam int BIT_MODE_LO = 6;
	localparam int BIT_MP = 5;
	localparam int BIT_REN = 4;
	localparam int BIT_TB8 = 3;
	localparam int BIT_RB8 = 2;
	localparam int BIT_TI = 1;
	localparam int BIT_RI = 0;
	localparam int BIT_DOUBLE = 7;
	localparam int BIT_FE_SEL = 6;
	localparam int BIT_T3_SEL = 6;
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [7:0] RST_PWR = 8'h10;
	localparam logic [7:0] PWR_WMASK = 8'hDF;
	localparam logic [7:0] T3_WMASK = 8'hFF;
	localparam logic [4:0] DIV_TIMER = 5'h10;
	localparam logic [4:0] DIV_TIMER_SLOW = 5'h1F;
	localparam int IRQ_W = 3;
	typedef enum logic [3:0] {
		SPC_SYNC8 = 4'h1,
		SPC_ASYNC10 = 4'h2,
		SPC_ASYNC11 = 4'h4,
		SPC_ASYNC11T = 4'h8
	} spc_mode_t;
endpackage

// [verilog/spc_sticky.sv]
// One sticky flag that hardware sets and software clears.
module spc_sticky (
	input wire logic clock,
	input wire logic reset,
	input wire logic set,
	input wire logic clr,
	input wire logic wr_en,
	input wire logic wr_val,
	output logic q
);
	// A set in the same cycle as a clear wins so that no event is lost.
	always_ff @(posedge clock) begin
		if (reset) begin
			q <= 1'b0;
		end else if (set) begin
			q <= 1'b1;
		end else if (clr) begin
			q <= 1'b0;
		end else if (wr_en) begin
			q <= wr_val;
		end
	end
endmodule

// [verilog/spc_accept.sv]
// Receive acceptance check for one serial port.
module spc_accept (
	input wire logic [1:0] mode,
	input wire logic mp_en,
	input wire logic [7:0] rx_byte,
	input wire logic rx_ninth,
	input wire logic [7:0] given_addr,
	input wire logic [7:0] bcast_addr,
	output logic accept
);
	logic addr_ok;
	assign addr_ok = (rx_byte == given_addr) || (rx_byte == bcast_addr);
	always_comb begin
		accept = 1'b1;
		// Mode 0 ignores the multiprocessor enable entirely.
		if (mode != 2'b00 && mp_en) begin
			// In mode 1 the ninth bit is the stop bit.
			accept = rx_ninth && addr_ok;
		end
	end
endmodule

// [verilog/spc_core.sv]
// Serial port control and status registers with frame event handling.
module spc_core (
	input wire logic clock,
	input wire logic reset,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [7:0] rdata,
	input wire logic p1_tx_end,
	input wire logic p1_rx_end,
	input wire logic [7:0] p1_rx_byte,
	input wire logic p1_rx_ninth,
	input wire logic p0_rx_end,
	input wire logic p0_rx_stop,
	input wire logic p1_irq_en,
	input wire logic t1_is_source,
	output logic [1:0] p1_mode,
	output logic p1_rx_allow,
	output logic p1_rx_start_ok,
	output logic p1_tx_ninth,
	output logic p1_tx_ninth_used,
	output logic [4:0] p1_timer_div,
	output logic p0_double,
	output logic irq
);
	logic [7:0] p1_ctl_r;
	logic [7:0] p0_ctl_r;
	logic [7:0] pwr_r;
	logic [7:0] t3_r;
	logic [7:0] p1_addr_r;
	logic [7:0] p1_bcast_r;
	logic [2:0] irq_mask_r;
	logic [2:0] irq_stat;
	logic [2:0] irq_evt;
	logic fe1;
	logic fe0;
	logic ti1;
	logic ri1;
	logic accept;
	logic rx_ok;
	logic async1;
	logic fe_sel1;
	logic fe_sel0;
	logic wr_p1;
	logic wr_p0;
	logic wr_stat;
	logic fe1_set;
	logic [1:0] mode_nxt;
	logic rx_allow_nxt;

	assign fe_sel1 = t3_r[spc_pkg::BIT_T3_SEL];
	assign fe_sel0 = pwr_r[spc_pkg::BIT_FE_SEL];
	assign wr_p1 = wr && addr == spc_pkg::ADDR_P1CTL;
	assign wr_p0 = wr && addr == spc_pkg::ADDR_P0CTL;
	assign wr_stat = wr && addr == spc_pkg::ADDR_IRQ_STAT;
	assign async1 = p1_ctl_r[spc_pkg::BIT_MODE_HI:spc_pkg::BIT_MODE_LO] != 2'b00;

	spc_accept u_accept (
		.mode(p1_ctl_r[spc_pkg::BIT_MODE_HI:spc_pkg::BIT_MODE_LO]),
		.mp_en(p1_ctl_r[spc_pkg::BIT_MP]),
		.rx_byte(p1_rx_byte),
		.rx_ninth(p1_rx_ninth),
		.given_addr(p1_addr_r),
		.bcast_addr(p1_bcast_r),
		.accept(accept)
	);

	// Receive end only counts while reception is enabled.
	assign rx_ok = p1_rx_end && p1_ctl_r[spc_pkg::BIT_REN] && accept;

	// Port-1 flags. Software may write them, but hardware only sets them.
	spc_sticky u_ti1 (
		.clock(clock),
		.reset(reset),
		.set(p1_tx_end),
		.clr(wr_stat && wdata[0]),
		.wr_en(wr_p1),
		.wr_val(wdata[spc_pkg::BIT_TI]),
		.q(ti1)
	);
	spc_sticky u_ri1 (
		.clock(clock),
		.reset(reset),
		.set(rx_ok),
		.clr(wr_stat && wdata[1]),
		.wr_en(wr_p1),
		.wr_val(wdata[spc_pkg::BIT_RI]),
		.q(ri1)
	);
	// The frame error flags are set regardless of the access select.
	// Only mode 1 brings the stop bit on the ninth input; in modes 2 and 3
	// a zero there is an ordinary data bit, not a framing fault.
	assign fe1_set = p1_rx_end && p1_ctl_r[spc_pkg::BIT_REN] &&
		!p1_rx_ninth &&
		p1_ctl_r[spc_pkg::BIT_MODE_HI:spc_pkg::BIT_MODE_LO] == 2'b01;
	spc_sticky u_fe1 (
		.clock(clock),
		.reset(reset),
		.set(fe1_set),
		.clr(wr_stat && wdata[2]),
		.wr_en(wr_p1 && fe_sel1),
		.wr_val(wdata[spc_pkg::BIT_MODE_HI]),
		.q(fe1)
	);
	spc_sticky u_fe0 (
		.clock(clock),
		.reset(reset),
		.set(p0_rx_end && !p0_rx_stop),
		.clr(1'b0),
		.wr_en(wr_p0 && fe_sel0),
		.wr_val(wdata[spc_pkg::BIT_MODE_HI]),
		.q(fe0)
	);

	// Port-1 control bits other than the flags.
	always_ff @(posedge clock) begin
		if (reset) begin
			p1_ctl_r <= spc_pkg::RST_BYTE;
		end else begin
			if (wr_p1) begin
				if (!fe_sel1) begin
					p1_ctl_r[spc_pkg::BIT_MODE_HI] <= wdata[spc_pkg::BIT_MODE_HI];
				end
				p1_ctl_r[6:3] <= wdata[6:3];
			end
			// Hardware capture of the ninth bit wins over a software write.
			if (rx_ok && async1) begin
				p1_ctl_r[spc_pkg::BIT_RB8] <= p1_rx_ninth;
			end else if (wr_p1) begin
				p1_ctl_r[spc_pkg::BIT_RB8] <= wdata[spc_pkg::BIT_RB8];
			end
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			p0_ctl_r <= spc_pkg::RST_BYTE;
		end else if (wr_p0) begin
			if (!fe_sel0) begin
				p0_ctl_r[spc_pkg::BIT_MODE_HI] <= wdata[spc_pkg::BIT_MODE_HI];
			end
			p0_ctl_r[6:0] <= wdata[6:0];
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			pwr_r <= spc_pkg::RST_PWR;
			t3_r <= spc_pkg::RST_BYTE;
			p1_addr_r <= spc_pkg::RST_BYTE;
			p1_bcast_r <= spc_pkg::RST_BYTE;
			irq_mask_r <= '0;
		end else if (wr) begin
			unique case (addr)
				spc_pkg::ADDR_PWR: pwr_r <= wdata & spc_pkg::PWR_WMASK;
				spc_pkg::ADDR_T3CTL: t3_r <= wdata & spc_pkg::T3_WMASK;
				spc_pkg::ADDR_P1ADDR: p1_addr_r <= wdata;
				spc_pkg::ADDR_P1BCAST: p1_bcast_r <= wdata;
				spc_pkg::ADDR_IRQ_MASK: irq_mask_r <= wdata[2:0];
				default: ;
			endcase
		end
	end

	// Summary status: port-1 tx done, rx done, frame error.
	assign irq_evt = {fe1, ri1, ti1};
	assign irq_stat = irq_evt;

	// Read path; unmapped addresses read as zero.
	always_ff @(posedge clock) begin
		if (reset) begin
			rdata <= spc_pkg::RST_BYTE;
		end else if (rd) begin
			unique case (addr)
				spc_pkg::ADDR_P1CTL: rdata <= {fe_sel1 ? fe1 :
					p1_ctl_r[7], p1_ctl_r[6:2], ti1, ri1};
				spc_pkg::ADDR_P0CTL: rdata <= {fe_sel0 ? fe0 :
					p0_ctl_r[7], p0_ctl_r[6:0]};
				spc_pkg::ADDR_PWR: rdata <= pwr_r;
				spc_pkg::ADDR_T3CTL: rdata <= t3_r;
				spc_pkg::ADDR_P1ADDR: rdata <= p1_addr_r;
				spc_pkg::ADDR_P1BCAST: rdata <= p1_bcast_r;
				spc_pkg::ADDR_IRQ_STAT: rdata <= {5'h00, irq_stat};
				spc_pkg::ADDR_IRQ_MASK: rdata <= {5'h00, irq_mask_r};
				default: rdata <= spc_pkg::RST_BYTE;
			endcase
		end else begin
			rdata <= spc_pkg::RST_BYTE;
		end
	end

	assign mode_nxt = p1_ctl_r[spc_pkg::BIT_MODE_HI:spc_pkg::BIT_MODE_LO];
	// Mode 0 starts only with enable set and no unread byte pending.
	assign rx_allow_nxt = p1_ctl_r[spc_pkg::BIT_REN] &&
		(mode_nxt != 2'b00 || !ri1);

	always_ff @(posedge clock) begin
		if (reset) begin
			p1_mode <= 2'b00;
			p1_rx_allow <= 1'b0;
			p1_rx_start_ok <= 1'b0;
			p1_tx_ninth <= 1'b0;
			p1_tx_ninth_used <= 1'b0;
			p1_timer_div <= spc_pkg::DIV_TIMER_SLOW;
			p0_double <= 1'b0;
			irq <= 1'b0;
		end else begin
			p1_mode <= mode_nxt;
			p1_rx_allow <= rx_allow_nxt;
			p1_rx_start_ok <= rx_allow_nxt && mode_nxt == 2'b00;
			// The ninth bit only goes out in the 11-bit modes.
			p1_tx_ninth_used <= mode_nxt[1];
			p1_tx_ninth <= mode_nxt[1] && p1_ctl_r[spc_pkg::BIT_TB8];
			p1_timer_div <= mode_nxt[0] ? spc_pkg::DIV_TIMER :
				spc_pkg::DIV_TIMER_SLOW;
			p0_double <= pwr_r[spc_pkg::BIT_DOUBLE] &&
				(p0_ctl_r[7:6] == 2'b10 ||
				(p0_ctl_r[6] && t1_is_source));
			irq <= (p1_irq_en && (ti1 || ri1)) ||
				|(irq_stat & irq_mask_r);
		end
	end

	// Every check sleeps through reset so that reset values never trip one.
	a_flag_hold_ti: assert property (
		@(posedge clock) disable iff (reset)
		ti1 && !wr_p1 && !wr_stat |=> ti1)
		else $error("tx done cleared by hardware");
	a_flag_hold_ri: assert property (
		@(posedge clock) disable iff (reset)
		ri1 && !wr_p1 && !wr_stat |=> ri1)
		else $error("rx done cleared by hardware");
	a_tx_done_set: assert property (
		@(posedge clock) disable iff (reset)
		p1_tx_end |=> ti1)
		else $error("tx done not set");
	a_rx_done_set: assert property (
		@(posedge clock) disable iff (reset)
		rx_ok |=> ri1)
		else $error("rx done not set");
	a_rx_gate_mp: assert property (
		@(posedge clock) disable iff (reset)
		p1_rx_end && p1_ctl_r[spc_pkg::BIT_REN] && async1 &&
		p1_ctl_r[spc_pkg::BIT_MP] && !p1_rx_ninth && !ri1 && !wr_p1
		|=> !ri1)
		else $error("rejected frame set rx done");
	a_rx_gate_addr: assert property (
		@(posedge clock) disable iff (reset)
		p1_rx_end && p1_ctl_r[spc_pkg::BIT_MODE_HI] &&
		p1_ctl_r[spc_pkg::BIT_MP] && p1_rx_byte != p1_addr_r &&
		p1_rx_byte != p1_bcast_r && !ri1 && !wr_p1 |=> !ri1)
		else $error("unaddressed frame set rx done");
	a_rx_blocked: assert property (
		@(posedge clock) disable iff (reset)
		p1_rx_end && !p1_ctl_r[spc_pkg::BIT_REN] && !ri1 && !wr_p1
		|=> !ri1)
		else $error("rx done while disabled");
	a_allow_ren: assert property (
		@(posedge clock) disable iff (reset)
		!p1_ctl_r[spc_pkg::BIT_REN] |=> !p1_rx_allow)
		else $error("reception allowed while disabled");
	a_mode0_mp_none: assert property (
		@(posedge clock) disable iff (reset)
		p1_rx_end && p1_ctl_r[spc_pkg::BIT_REN] && !async1 |=> ri1)
		else $error("mode 0 frame rejected");
	a_fe_set: assert property (
		@(posedge clock) disable iff (reset)
		p0_rx_end && !p0_rx_stop |=> fe0)
		else $error("fe0 missed");
	a_fe1_set: assert property (
		@(posedge clock) disable iff (reset)
		p1_rx_end && p1_ctl_r[spc_pkg::BIT_REN] && !p1_rx_ninth &&
		p1_ctl_r[spc_pkg::BIT_MODE_HI:spc_pkg::BIT_MODE_LO] == 2'b01
		|=> fe1)
		else $error("fe1 missed");
	a_fe1_write: assert property (
		@(posedge clock) disable iff (reset)
		wr_p1 && fe_sel1 && !p1_rx_end
		|=> fe1 == $past(wdata[spc_pkg::BIT_MODE_HI]))
		else $error("frame error flag not written");
	a_mode_kept: assert property (
		@(posedge clock) disable iff (reset)
		wr_p1 && fe_sel1 |=> $stable(p1_ctl_r[spc_pkg::BIT_MODE_HI]))
		else $error("port 1 mode bit written under select");
	a_fe0_route: assert property (
		@(posedge clock) disable iff (reset)
		wr_p0 && fe_sel0 |=> $stable(p0_ctl_r[spc_pkg::BIT_MODE_HI]))
		else $error("port 0 mode bit written under select");
	a_ninth_tx: assert property (
		@(posedge clock) disable iff (reset)
		##1 p1_tx_ninth |-> $past(mode_nxt[1]))
		else $error("ninth bit sent in short mode");
	a_rb8_capture: assert property (
		@(posedge clock) disable iff (reset)
		rx_ok && async1
		|=> p1_ctl_r[spc_pkg::BIT_RB8] == $past(p1_rx_ninth))
		else $error("ninth bit not captured");
	a_start_mode0: assert property (
		@(posedge clock) disable iff (reset)
		p1_rx_start_ok |-> !$past(ri1) && $past(mode_nxt) == 2'b00 &&
		$past(p1_ctl_r[spc_pkg::BIT_REN]))
		else $error("mode 0 start with rx done set");
	a_div_mode: assert property (
		@(posedge clock) disable iff (reset)
		mode_nxt[0] |=> p1_timer_div == spc_pkg::DIV_TIMER)
		else $error("timer divider wrong in timer mode");
	a_double_m2: assert property (
		@(posedge clock) disable iff (reset)
		pwr_r[spc_pkg::BIT_DOUBLE] && p0_ctl_r[7:6] == 2'b10
		|=> p0_double)
		else $error("port 0 rate not doubled in mode 2");
	a_irq_raise: assert property (
		@(posedge clock) disable iff (reset)
		p1_irq_en && (ti1 || ri1) |=> irq)
		else $error("irq missing with done flag");
	a_status_clr: assert property (
		@(posedge clock) disable iff (reset)
		wr_stat && wdata[0] && !p1_tx_end |=> !ti1)
		else $error("tx done not cleared from status");
	c_tx_done: cover property (@(posedge clock) p1_tx_end ##1 irq);
	c_rx_accept: cover property (@(posedge clock)
		rx_ok && p1_ctl_r[spc_pkg::BIT_MP]);
	c_fe_read: cover property (@(posedge clock) rd && fe_sel1 && fe1);
	c_fe1_set: cover property (@(posedge clock) fe1_set);
	c_status_clr: cover property (@(posedge clock) wr_stat && ti1);
endmodule

// [dv/spc_remote.sv]
// Remote serial transceiver model that reports frame ends to the port logic.
module spc_remote (
	input wire logic clock,
	output logic tx_end,
	output logic rx_end,
	output logic [7:0] rx_byte,
	output logic rx_ninth,
	output logic p0_end,
	output logic p0_stop
);
	timeunit 1ns;
	timeprecision 1ns;

	initial begin
		tx_end = 1'b0;
		rx_end = 1'b0;
		p0_end = 1'b0;
		rx_byte = 8'h00;
		rx_ninth = 1'b0;
		p0_stop = 1'b1;
	end

	// A larger gap models a slow far end; between frames the data lines
	// invert so that a stale value can never pass for a fresh one.
	task automatic frame(input logic [2:0] kind, input logic [7:0] b,
		input logic n, input int gap);
		repeat (gap) @(posedge clock);
		rx_byte <= b;
		rx_ninth <= n;
		p0_stop <= n;
		{p0_end, rx_end, tx_end} <= kind;
		@(posedge clock);
		{p0_end, rx_end, tx_end} <= 3'h0;
		rx_byte <= ~b;
		rx_ninth <= ~n;
		p0_stop <= ~n;
	endtask
endmodule

// [dv/test_serial_port_control_status.sv]
// Self-checking bench for the serial port control and status block.
module test_serial_port_control_status;
	timeunit 1ns;
	timeprecision 1ns;
	logic clock, reset, wr, rd, p1_irq_en, t1_is_source;
	logic [7:0] addr, wdata, rdata, p1_rx_byte;
	logic p1_tx_end, p1_rx_end, p1_rx_ninth, p0_rx_end, p0_rx_stop;
	logic [1:0] p1_mode, m, kd;
	logic p1_rx_allow, p1_rx_start_ok, p1_tx_ninth, p1_tx_ninth_used;
	logic p0_double, irq, en, n, acc, rxv, irqx, fex;
	logic [4:0] p1_timer_div;
	logic [7:0] q, d, b, ctl, msk;
	logic [7:0] rst_a [6] = '{8'h87, 8'h98, 8'hF8, 8'hC4, 8'hE0, 8'h5A};
	int n_mismatch = 0, compares = 0, k;
	int seed = 32'hab15d05b;

	spc_core u_dut (.clock, .reset, .addr, .wdata, .wr, .rd, .rdata,
		.p1_tx_end, .p1_rx_end, .p1_rx_byte, .p1_rx_ninth, .p0_rx_end,
		.p0_rx_stop, .p1_irq_en, .t1_is_source, .p1_mode, .p1_rx_allow,
		.p1_rx_start_ok, .p1_tx_ninth, .p1_tx_ninth_used, .p1_timer_div,
		.p0_double, .irq);
	spc_remote u_rem (.clock, .tx_end(p1_tx_end), .rx_end(p1_rx_end),
		.rx_byte(p1_rx_byte), .rx_ninth(p1_rx_ninth), .p0_end(p0_rx_end),
		.p0_stop(p0_rx_stop));

	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
		@(posedge clock);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge clock);
		wr <= 1'b0;
	endtask

	task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
		@(posedge clock);
		addr <= a;
		rd <= 1'b1;
		@(posedge clock);
		rd <= 1'b0;
		#1 v = rdata;
	endtask

	task automatic print_verdict();
		$display("mismatches %0d compares %0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// Roughly ten times the expected run, so a hang cannot go unnoticed.
	initial begin
		#400000;
		n_mismatch++;
		print_verdict();
	end

	initial begin
		reset = 1'b1;
		wr = 1'b0;
		rd = 1'b0;
		addr = 8'h00;
		wdata = 8'h00;
		p1_irq_en = 1'b0;
		t1_is_source = 1'b0;
		fex = 1'b0;
		repeat (3) @(posedge clock);
		reset <= 1'b0;
		wr_reg(8'h5A, 8'h77);
		for (k = 0; k < 6; k++) begin
			rd_reg(rst_a[k], q);
			chk(q, k == 0 ? spc_pkg::RST_PWR : spc_pkg::RST_BYTE);
		end
		chk({3'h0, p1_timer_div}, 8'h1F);
		wr_reg(8'hE2, 8'h5A);
		wr_reg(8'hE3, 8'hFF);
		for (k = 0; k < 80; k++) begin
			d = $random(seed);
			en = $random(seed);
			n = $random(seed);
			kd = $random(seed);
			msk = $random(seed) & 7;
			b = $random(seed);
			if (b[0])
				b = b[1] ? 8'h5A : 8'hFF;
			@(posedge clock);
			p1_irq_en <= en;
			wr_reg(8'hE1, msk);
			wr_reg(8'hF8, d);
			u_rem.frame({1'b0, kd}, b, n, 1 + k % 3);
			m = d[7:6];
			fex = fex | (kd[1] && m == 1 && !n && d[4]);
			acc = d[4] && !(m != 0 && d[5] && (!n || (b != 8'h5A && b != 8'hFF)));
			rxv = kd[1] && acc;
			ctl = d;
			ctl[0] = d[0] | rxv;
			ctl[1] = d[1] | kd[0];
			if (rxv && m != 0)
				ctl[2] = n;
			irqx = (en && (ctl[0] || ctl[1])) || (msk[0] && ctl[1]) ||
				(msk[1] && ctl[0]) || (msk[2] && fex);
			rd_reg(8'hF8, q);
			chk(q, ctl);
			chk({p1_mode, p1_rx_allow, p1_rx_start_ok, p1_tx_ninth,
				p1_tx_ninth_used, irq, 1'b0}, {m, ctl[4] && (m != 0 || !ctl[0]),
				m == 0 && ctl[4] && !ctl[0], m[1] && ctl[3], m[1], irqx,
				1'b0});
			chk({3'h0, p1_timer_div}, m[0] ? 8'h10 : 8'h1F);
			rd_reg(8'hE0, q);
			chk(q, {5'h00, fex, ctl[0], ctl[1]});
		end
		wr_reg(8'hE0, 8'h07);
		rd_reg(8'hF8, q);
		chk(q & 8'h03, 8'h00);
		rd_reg(8'hE0, q);
		chk(q, 8'h00);
		wr_reg(8'h87, 8'h80);
		for (k = 0; k < 8; k++) begin
			@(posedge clock);
			t1_is_source <= k[2];
			wr_reg(8'h98, {k[1:0], 6'h00});
			rd_reg(8'h98, q);
			chk(q, {k[1:0], 6'h00});
			chk({7'h00, p0_double}, {7'h00, k[1:0] == 2 || (k[0] && k[2])});
		end
		wr_reg(8'h98, 8'h50);
		u_rem.frame(3'h4, 8'h00, 1'b0, 2);
		wr_reg(8'h87, 8'hC0);
		rd_reg(8'h98, q);
		chk(q & 8'h80, 8'h80);
		wr_reg(8'h98, 8'h50);
		rd_reg(8'h98, q);
		chk(q & 8'h80, 8'h00);
		u_rem.frame(3'h4, 8'h00, 1'b0, 1);
		wr_reg(8'h87, 8'h80);
		rd_reg(8'h98, q);
		chk(q & 8'hF0, 8'h50);
		wr_reg(8'hF8, 8'h50);
		u_rem.frame(3'h2, 8'h00, 1'b0, 1);
		wr_reg(8'hC4, 8'h40);
		rd_reg(8'hF8, q);
		chk(q & 8'h80, 8'h80);
		wr_reg(8'hF8, 8'h50);
		rd_reg(8'hF8, q);
		chk(q & 8'h80, 8'h00);
		wr_reg(8'hF8, 8'hD0);
		wr_reg(8'hC4, 8'h00);
		rd_reg(8'hF8, q);
		chk(q & 8'hC0, 8'h40);
		print_verdict();
	end
endmodule
